// file: hw/amp_cfg_pkg.sv
// Constants and carrier types for the tape amplifier configuration bank.
// Assumes a single general clock domain; the serial pins are asynchronous.
package amp_cfg_pkg;
  // Serial frame layout
  localparam int unsigned BYTE_W        = 8;          // Address and data width
  localparam int unsigned FRAME_BITS    = 16;         // Address byte then data byte
  localparam logic [7:0]  STATUS_ADDR   = 8'hff;      // Status byte address
  localparam logic [7:0]  LAST_CFG_ADDR = 8'h05;      // Highest control entry
  localparam int unsigned CFG_ENTRIES   = 6;          // Control entries 0..5
  // Control entry offsets
  localparam logic [7:0] FILTER_AND_ENABLE_CFG = 8'h00; // Filter, bias mode, enables
  localparam logic [7:0] PATH_AND_PREAMP_CFG   = 8'h01; // Routing and preamp gain
  localparam logic [7:0] GAIN_CFG              = 8'h02; // Fixed gain setup
  localparam logic [7:0] DC_BIAS_LEVEL         = 8'h03; // Bias DAC code
  localparam logic [7:0] WRITE_CURRENT_CFG     = 8'h04; // Write mode and DAC code
  localparam logic [7:0] SENSE_CURRENT_CFG     = 8'h05; // Sense range and DAC code
  localparam logic [7:0] CFG_RESET             = 8'h00; // Reset value of every entry
  // Status byte field positions
  localparam int unsigned ST_GAIN_LSB = 4;  // Actual gain, bits 7:4
  localparam int unsigned ST_HINT     = 3;  // Gain direction hint
  localparam int unsigned ST_LOW5V    = 2;  // 5 V supply fail
  localparam int unsigned ST_WFAULT   = 1;  // Write fault
  localparam int unsigned ST_LOW12V   = 0;  // 12 V supply fail
  // Gain loop timing
  localparam int unsigned CLK_PERIOD_NS = 25;    // General clock period
  localparam int unsigned AGC_STEP_NS   = 1000;  // Least time between gain steps
  localparam int unsigned AGC_STEP_CYC  = (AGC_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  GAIN_MAX      = 4'hf;  // Top of the 4-bit gain code

  // Decoded control fields driven towards the analog sections
  typedef struct packed {
    logic [1:0] filter_corner_sel;      // 00 1, 01 2, 10 4, 11 10 MHz
    logic [1:0] bias_mode_sel;          // Bias circuit range
    logic       head_current_source_on; // Sense current source
    logic       read_chain_on;          // Read circuits
    logic       refs_on;                // Internal references
    logic       hold_pin_role;          // 0 AGC hold, 1 servo select
    logic       highpass_path_on;       // 0 bypassed
    logic [1:0] vga_input_sel;          // Effective gain stage input
    logic [1:0] bias_input_sel;         // Bias circuit input
    logic [1:0] preamp_gain_sel;        // Preamp gain step
    logic       gain_range_high;        // 10..25 dB range
    logic       gain_fixed_mode;        // Gain loop off
    logic [4:0] dc_bias_level_code;     // Code times 45 mV
    logic       write_input_mode;       // 0 return to zero, 1 level
    logic [6:0] write_current_code;     // 125*(code+1)/128 mA
    logic       sense_range_double;     // 30 mA full scale
    logic [6:0] sense_current_code;     // 15*(code+1)/128 mA
  } cfg_t;

  // Analog-side event and level inputs
  typedef struct packed {
    logic low5v;        // 5 V supply below threshold
    logic low12v;       // 12 V supply below threshold
    logic write_fault;  // Head open or shorted while writing
    logic level_high;   // Output above target level
    logic level_low;    // Output below target level
  } sense_t;
endpackage

// file: hw/tape_amp_serial_config_regs.sv
// Serial-programmed configuration and status bank of a tape read/write amplifier.
// Assumes serial pins and analog sense lines are asynchronous to clock and that
// the general clock runs at least eight times the serial clock.
// Summary of operation
// - General clock times status access and gain loop
// - Frame is address byte then data byte
// - Address FF returns the status byte
// - Six control entries at addresses 0..5
// - Filter corner select in entry 0
// - Bias mode select in entry 0
// - Five-bit bias level code in entry 3
// - Single-bit enables, one means active
// - Hold pin role chooses hold or servo
// - Gain input select; servo forced when pin low and hold pin role is servo
// - Bias input select routing
// - Preamp gain select
// - Gain loop run, freeze, maximum or off
// - Fixed gain code with range bit
// - Write input mode return-to-zero or level
// - Seven-bit write current code
// - Seven-bit sense code with range double
// - Status byte field layout
// - Hint bit: 0 increase, 1 decrease
// - Fault flags sticky until status read
// - Write polarity toggles per mode
`timescale 1ns/1ps
module tape_amp_serial_config_regs
  import amp_cfg_pkg::*;
#(
  parameter int unsigned AGC_STEP = AGC_STEP_CYC  // Cycles between gain steps
) (
  input  wire logic   clock,          // General clock
  input  wire logic   rst_n,          // Synchronous reset, active low
  input  wire logic   clk_en,         // Freezes all state when low
  input  wire logic   sclk,           // Serial clock pin
  input  wire logic   frame_n,        // Serial frame enable pin, active low
  input  wire logic   sdata_in,       // Serial data pin, input side
  output logic        sdata_out,      // Serial data pin, output side
  output logic        sdata_oe,       // Serial data pin drive enable
  input  wire logic   gain_freeze,    // Gain freeze pin
  input  wire logic   write_data_in,  // Write data pin
  input  wire sense_t sense_in,       // Analog sense lines
  output cfg_t        cfg,            // Registered control fields
  output logic [3:0]  actual_gain,    // Gain code applied to the stage
  output logic        write_polarity  // Write current direction
);

  // Two-flop synchronisers; the first stage feeds only the second
  logic [9:0] sync1_r;                // First stage
  logic [9:0] sync2_r;                // Second stage
  logic       sclk_d_r;               // Delayed serial clock for edges
  logic       wd_d_r;                 // Delayed write data for edges
  wire  [9:0] raw_in = {sclk, frame_n, sdata_in, gain_freeze, write_data_in, sense_in};
  always_ff @(posedge clock) begin
    if (clk_en) begin
      sync1_r  <= raw_in;
      sync2_r  <= sync1_r;
      sclk_d_r <= sync2_r[9];
      wd_d_r   <= sync2_r[5];
    end
  end

  // Synchronised views
  wire    sclk_s    = sync2_r[9];     // Serial clock
  wire    frame_s_n = sync2_r[8];     // Frame enable, active low
  wire    sdi_s     = sync2_r[7];     // Serial input bit
  wire    freeze_s  = sync2_r[6];     // Gain freeze pin
  wire    wd_s      = sync2_r[5];     // Write data
  sense_t sense_s;                    // Analog lines
  assign  sense_s   = sync2_r[4:0];
  wire    sclk_rise = sclk_s & ~sclk_d_r;  // Sample edge
  wire    wd_fall   = ~wd_s & wd_d_r;      // Falling write data
  wire    wd_edge   = wd_s ^ wd_d_r;       // Any write data change

  // Control entries
  logic [7:0] cfg_mem_r [CFG_ENTRIES];  // Six control bytes

  // Serial frame state
  logic [4:0] bit_cnt_r;              // Bits taken in this frame
  logic [7:0] addr_r;                 // Captured address
  logic [7:0] rx_r;                   // Incoming shift register
  logic [7:0] tx_r;                   // Outgoing status shift register
  logic       read_r;                 // Frame is a status read
  logic       lo5_r;                  // Sticky 5 V fail
  logic       lo12_r;                 // Sticky 12 V fail
  logic       wfault_r;               // Sticky write fault
  logic [3:0] gain_r;                 // Loop gain code
  logic [$clog2(AGC_STEP+1)-1:0] step_cnt_r;  // Gain step timer
  logic       pol_r;                  // Write polarity

  // Frame decode
  wire        in_frame   = ~frame_s_n;
  wire        take_bit   = in_frame & sclk_rise & (bit_cnt_r < 5'(FRAME_BITS));
  wire        addr_done  = take_bit & (bit_cnt_r == 5'(BYTE_W - 1));
  wire        data_done  = take_bit & (bit_cnt_r == 5'(FRAME_BITS - 1));
  wire [7:0]  addr_full  = {rx_r[6:0], sdi_s};
  wire [7:0]  data_full  = {rx_r[6:0], sdi_s};
  wire        is_status  = (addr_full == STATUS_ADDR);
  wire        cfg_write  = data_done & ~read_r & (addr_r <= LAST_CFG_ADDR);
  wire        status_clr = addr_done & is_status;

  // Gain loop decisions
  wire        loop_on    = ~cfg.gain_fixed_mode & freeze_s;
  wire        servo_max  = ~cfg.gain_fixed_mode & ~freeze_s & cfg.hold_pin_role;
  wire        step_now   = (step_cnt_r == '0);
  wire        gain_up    = sense_s.level_low & (gain_r != GAIN_MAX);
  wire        gain_dn    = sense_s.level_high & (gain_r != 4'h0);
  wire        hint       = sense_s.level_high;
  wire [3:0]  applied    = cfg.gain_fixed_mode ? cfg_mem_r[2][3:0] : gain_r;

  // Status snapshot
  wire [7:0]  status_now = {applied, hint, lo5_r, wfault_r, lo12_r};

  // Serial shift and frame tracking, driven by the general clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bit_cnt_r <= '0;
      addr_r    <= '0;
      rx_r      <= '0;
      tx_r      <= '0;
      read_r    <= 1'b0;
    end else if (clk_en) begin
      if (!in_frame) begin          // Frame closed, restart
        bit_cnt_r <= '0;
        read_r    <= 1'b0;
      end else if (take_bit) begin
        bit_cnt_r <= bit_cnt_r + 5'd1;
        rx_r      <= data_full;
        if (addr_done) begin        // Address complete
          addr_r <= addr_full;
          read_r <= is_status;
          tx_r   <= status_now;
        end else if (bit_cnt_r >= 5'(BYTE_W)) begin
          tx_r   <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  // Control entries; one per generate lane
  for (genvar i = 0; i < CFG_ENTRIES; i++) begin : g_cfg
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        cfg_mem_r[i] <= CFG_RESET;
      end else if (clk_en && cfg_write && addr_r == 8'(i)) begin
        cfg_mem_r[i] <= data_full;
      end
    end
  end

  // Sticky flags; a new event wins over the read clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lo5_r    <= 1'b0;
      lo12_r   <= 1'b0;
      wfault_r <= 1'b0;
    end else if (clk_en) begin
      lo5_r    <= (lo5_r & ~status_clr) | sense_s.low5v;
      lo12_r   <= (lo12_r & ~status_clr) | sense_s.low12v;
      wfault_r <= (wfault_r & ~status_clr) | sense_s.write_fault;
    end
  end

  // Gain loop on the general clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gain_r     <= '0;
      step_cnt_r <= '0;
    end else if (clk_en) begin
      step_cnt_r <= step_now ? ($bits(step_cnt_r))'(AGC_STEP - 1) : step_cnt_r - 1'b1;
      if (servo_max) begin
        gain_r <= GAIN_MAX;
      end else if (loop_on && step_now) begin
        if (gain_up) begin
          gain_r <= gain_r + 4'h1;
        end else if (gain_dn) begin
          gain_r <= gain_r - 4'h1;
        end
      end
    end
  end

  // Write polarity; pin edges choose the toggle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pol_r <= 1'b0;
    end else if (clk_en) begin
      if (cfg.write_input_mode ? wd_edge : wd_fall) begin
        pol_r <= ~pol_r;
      end
    end
  end

  // Field decode into registered outputs
  cfg_t cfg_nxt;                      // Next field image
  always_comb begin
    cfg_nxt.filter_corner_sel      = cfg_mem_r[0][6:5];
    cfg_nxt.bias_mode_sel          = cfg_mem_r[0][4:3];
    cfg_nxt.head_current_source_on = cfg_mem_r[0][2];
    cfg_nxt.read_chain_on          = cfg_mem_r[0][1];
    cfg_nxt.refs_on                = cfg_mem_r[0][0];
    cfg_nxt.hold_pin_role          = cfg_mem_r[1][7];
    cfg_nxt.highpass_path_on       = cfg_mem_r[1][6];
    cfg_nxt.vga_input_sel          = (cfg_mem_r[1][7] & ~freeze_s) ? 2'b00 : cfg_mem_r[1][5:4];
    cfg_nxt.bias_input_sel         = cfg_mem_r[1][3:2];
    cfg_nxt.preamp_gain_sel        = cfg_mem_r[1][1:0];
    cfg_nxt.gain_range_high        = cfg_mem_r[2][5];
    cfg_nxt.gain_fixed_mode        = cfg_mem_r[2][4];
    cfg_nxt.dc_bias_level_code     = cfg_mem_r[3][4:0];
    cfg_nxt.write_input_mode       = cfg_mem_r[4][7];
    cfg_nxt.write_current_code     = cfg_mem_r[4][6:0];
    cfg_nxt.sense_range_double     = cfg_mem_r[5][7];
    cfg_nxt.sense_current_code     = cfg_mem_r[5][6:0];
  end

  // Output flops; one cycle behind the entries
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg            <= '0;
      actual_gain    <= '0;
      write_polarity <= 1'b0;
      sdata_out      <= 1'b0;
      sdata_oe       <= 1'b0;
    end else if (clk_en) begin
      cfg            <= cfg_nxt;
      actual_gain    <= applied;
      write_polarity <= pol_r;
      sdata_out      <= tx_r[7];
      sdata_oe       <= in_frame & read_r & (bit_cnt_r >= 5'(BYTE_W)) & (bit_cnt_r < 5'(FRAME_BITS));
    end
  end

  // Checks guarding the logic above
  property p_write_lands;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && cfg_write) |=> (cfg_mem_r[addr_r[2:0]] == $past(data_full));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("control write lost");

  property p_no_status_write;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && data_done && read_r) |=> ($stable(cfg_mem_r[0]) && $stable(cfg_mem_r[5]));
  endproperty
  a_no_status_write: assert property (p_no_status_write) else $error("status frame wrote entry");

  property p_read_snapshot;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && addr_done && is_status) |=> (read_r && tx_r == $past(status_now));
  endproperty
  a_read_snapshot: assert property (p_read_snapshot) else $error("status not loaded");

  property p_sticky;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && lo5_r && !status_clr) |=> lo5_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped early");

  property p_set_wins;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && status_clr && sense_s.write_fault) |=> wfault_r;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("fault lost at clear");

  property p_servo_max;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && servo_max) ##1 clk_en |=> (actual_gain == GAIN_MAX);
  endproperty
  a_servo_max: assert property (p_servo_max) else $error("servo gain not maximum");

  property p_fixed_gain;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && cfg.gain_fixed_mode && cfg_mem_r[2][4]) |=> (actual_gain == $past(cfg_mem_r[2][3:0]));
  endproperty
  a_fixed_gain: assert property (p_fixed_gain) else $error("fixed gain not applied");

  property p_freeze_holds;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && !cfg.gain_fixed_mode && !freeze_s && !cfg.hold_pin_role) |=> $stable(gain_r);
  endproperty
  a_freeze_holds: assert property (p_freeze_holds) else $error("gain moved while frozen");

  property p_rtz_toggle;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && !cfg.write_input_mode && wd_fall) |=> (pol_r != $past(pol_r));
  endproperty
  a_rtz_toggle: assert property (p_rtz_toggle) else $error("polarity missed falling edge");

  // Level mode must follow every change of the pin, rising ones too
  property p_nrz_toggle;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && cfg.write_input_mode && wd_edge) |=> (pol_r != $past(pol_r));
  endproperty
  a_nrz_toggle: assert property (p_nrz_toggle) else $error("polarity missed level change");

  // A status read with no fresh event leaves the flag clear
  property p_read_clears;
    @(posedge clock) disable iff (!rst_n)
      (clk_en && status_clr && !sense_s.low12v) |=> !lo12_r;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag not cleared by read");

  property p_oe_window;
    @(posedge clock) disable iff (!rst_n)
      sdata_oe |-> $past(read_r);
  endproperty
  a_oe_window: assert property (p_oe_window) else $error("driving outside status read");

endmodule

// file: dv/host_link_model.sv
// Host controller model for the three-wire configuration link.
// Assumes the general clock toggles on its own; serial clock rests low between frames.
`timescale 1ns/1ps
module host_link_model (
  input  wire logic clock,     // General clock, paces the link
  input  wire logic sdata_out, // Device side of the data pin
  input  wire logic sdata_oe,  // Device drives the data pin
  output logic      sclk,      // Serial clock, still outside frames
  output logic      frame_n,   // Frame enable, active low
  output logic      sdata_in   // Resolved data pin level
);
  logic drv_r; // Host level on the data pin

  // Wire level: device wins while it drives
  assign sdata_in = sdata_oe ? sdata_out : drv_r;

  // Idle link at time zero
  initial begin
    sclk = 1'b0;
    frame_n = 1'b1;
    drv_r = 1'b0;
  end

  // Each serial level lasts 4 general clocks, 200 ns period
  task automatic half();
    repeat (4) @(negedge clock);
  endtask

  // One frame; returns the data phase as seen before each rise
  task automatic xfer(input logic [7:0] addr, input logic [7:0] data, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {addr, data};
    rd = 8'h00;
    frame_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      // Released pin shows the inverse, so a stale bit cannot pass
      drv_r = (addr == 8'hff && i < 8) ? ~sdata_out : sh[i];
      half();
      if (i < 8) begin
        rd[i] = sdata_in;
      end
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    frame_n = 1'b1;
    drv_r = ~drv_r;
    // Clock kept running until the entry has landed
    repeat (8) @(negedge clock);
  endtask
endmodule

// file: dv/tape_amp_serial_config_regs_tb.sv
// Self-checking bench for the serial configuration and status bank.
// Assumes the host model paces frames; gain step shortened to 4 clocks.
`timescale 1ns/1ps
module tape_amp_serial_config_regs_tb;
  import amp_cfg_pkg::*;
  localparam int unsigned STEP = 4; // Short gain step for simulation
  logic       clock, rst_n, clk_en, sclk, frame_n, sdata_in, sdata_out, sdata_oe;
  logic       gain_freeze, write_data_in, write_polarity, exp_pol;
  sense_t     sense_in;
  cfg_t       cfg;
  logic [3:0] actual_gain;
  logic [7:0] rd;
  logic [7:0] ent [6]; // Expected control entries
  int         err_total, tests_run;

  tape_amp_serial_config_regs #(.AGC_STEP(STEP)) i_tape_amp_serial_config_regs (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .sclk(sclk), .frame_n(frame_n),
    .sdata_in(sdata_in), .sdata_out(sdata_out), .sdata_oe(sdata_oe), .gain_freeze(gain_freeze),
    .write_data_in(write_data_in), .sense_in(sense_in), .cfg(cfg), .actual_gain(actual_gain),
    .write_polarity(write_polarity));
  host_link_model i_host_link_model (.clock(clock), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
    .sclk(sclk), .frame_n(frame_n), .sdata_in(sdata_in));

  // 40 MHz general clock
  always #12.5 clock = ~clock;

  // Verdict and end of run
  task automatic close_out();
    $display("checks run %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Value comparison
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Expected field map from the entry bytes; unused upper bits and the entry 2 gain code dropped
  function automatic cfg_t exp_cfg();
    return cfg_t'({ent[0][6:0], ent[1], ent[2][5:4], ent[3][4:0], ent[4], ent[5]});
  endfunction

  // Serial write, tracking what the bank should now hold
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_link_model.xfer(a, d, rd);
    if (a <= LAST_CFG_ADDR) begin
      ent[a[2:0]] = d;
    end
  endtask

  // Bounded wait for a gain value
  task automatic wait_gain(input logic [3:0] g);
    int n;
    n = 0;
    while (actual_gain !== g && n < 40 * STEP) begin
      @(negedge clock);
      n++;
    end
    chk("actual_gain", g, actual_gain);
    if (actual_gain !== g) begin    // Timed out: mismatch already counted
      close_out();
    end
  endtask

  // All six entries with three patterns
  task automatic t_cfg_write();
    foreach (ent[i]) ent[i] = CFG_RESET;
    chk("cfg after reset", exp_cfg(), cfg);
    for (int p = 0; p < 3; p++) begin
      for (int a = 0; a < 6; a++) begin
        wr(a[7:0], (p == 2) ? 8'hff : (8'ha5 ^ (8'h11 * a[7:0]) ^ {8{p[0]}}));
      end
      chk("cfg fields", exp_cfg(), cfg);
    end
  endtask

  // Unmapped addresses change nothing
  task automatic t_refused();
    wr(8'h06, 8'h3c);
    wr(8'hfe, 8'hc3);
    chk("cfg unchanged", exp_cfg(), cfg);
  endtask

  // Sticky flags, snapshot layout and clear on read
  task automatic t_status();
    wr(8'h02, 8'h19);
    sense_in = '{low5v: 1'b1, low12v: 1'b0, write_fault: 1'b1, level_high: 1'b1, level_low: 1'b0};
    repeat (4) @(negedge clock);
    sense_in.low5v = 1'b0;
    sense_in.write_fault = 1'b0;
    repeat (8) @(negedge clock);
    chk("fixed gain", 4'h9, actual_gain);
    i_host_link_model.xfer(STATUS_ADDR, 8'h00, rd);
    chk("status 1", 8'h9e, rd);
    sense_in.low12v = 1'b1;
    sense_in.write_fault = 1'b1;  // Held across the read clear: set must win
    repeat (4) @(negedge clock);
    sense_in.low12v = 1'b0;
    i_host_link_model.xfer(STATUS_ADDR, 8'h00, rd);
    chk("status 2", 8'h9b, rd);
    sense_in.write_fault = 1'b0;
    i_host_link_model.xfer(STATUS_ADDR, 8'h00, rd);
    chk("status 3", 8'h9a, rd);
    sense_in.level_high = 1'b0;
    repeat (4) @(negedge clock);
    i_host_link_model.xfer(STATUS_ADDR, 8'h00, rd);
    chk("status 4", 8'h90, rd);
  endtask

  // Gain loop: run, freeze, servo maximum
  task automatic t_agc();
    wr(8'h01, 8'h00);
    sense_in = '{low5v: 1'b0, low12v: 1'b0, write_fault: 1'b0, level_high: 1'b0, level_low: 1'b1};
    gain_freeze = 1'b1;
    wr(8'h02, 8'h00);
    wait_gain(GAIN_MAX);
    sense_in.level_low = 1'b0;
    sense_in.level_high = 1'b1;
    gain_freeze = 1'b0;
    repeat (10 * STEP) @(negedge clock);
    chk("frozen gain", GAIN_MAX, actual_gain);
    gain_freeze = 1'b1;
    wait_gain(4'h0);
    wr(8'h01, 8'h80);
    gain_freeze = 1'b0;
    wait_gain(GAIN_MAX);
  endtask

  // Write polarity in both input modes
  task automatic t_polarity();
    wr(8'h04, 8'h00);
    for (int k = 0; k < 8; k++) begin
      if (k == 4) begin
        wr(8'h04, 8'h80);
      end
      write_data_in = ~write_data_in;
      if (k >= 4 || !write_data_in) begin
        exp_pol = ~exp_pol;
      end
      repeat (8) @(negedge clock);
      chk("write_polarity", exp_pol, write_polarity);
    end
  endtask

  // Enable low freezes the pin pipeline; the edge shows once released
  task automatic t_freeze();
    clk_en = 1'b0;
    write_data_in = ~write_data_in;
    repeat (8) @(negedge clock);
    chk("frozen polarity", exp_pol, write_polarity);
    clk_en = 1'b1;
    exp_pol = ~exp_pol;
    repeat (8) @(negedge clock);
    chk("released polarity", exp_pol, write_polarity);
  endtask

  // Reset in mid-run returns entries and outputs to zero
  task automatic t_reset();
    rst_n = 1'b0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    exp_pol = 1'b0;
    foreach (ent[i]) ent[i] = CFG_RESET;
    repeat (3) @(negedge clock);
    chk("cfg after reset", exp_cfg(), cfg);
    chk("gain after reset", 4'h0, actual_gain);
    chk("polarity after reset", exp_pol, write_polarity);
    wr(8'h03, 8'h1f);
    chk("cfg after reset write", exp_cfg(), cfg);
  endtask

  // Main sequence
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    gain_freeze = 1'b1;
    write_data_in = 1'b0;
    exp_pol = 1'b0;
    sense_in = '0;
    err_total = 0;
    tests_run = 0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    t_cfg_write();
    t_refused();
    t_status();
    t_agc();
    t_polarity();
    t_freeze();
    t_reset();
    close_out();
  end
endmodule
